// *** inc/swsc_pkg.sv ***
// Package of constants and types for the slave watchdog and state control block
package swsc_pkg;

  // Core clock and watchdog base clock rates
  localparam int unsigned CORE_CLK_HZ = 100_000_000; // Core clock in Hz
  localparam int unsigned BASE_CLK_HZ = 25_000_000; // Watchdog base clock in Hz
  localparam int unsigned BASE_DIV = CORE_CLK_HZ / BASE_CLK_HZ; // Core cycles per base tick

  // Register word width and offsets
  localparam int unsigned REG_W = 16; // Register data width
  localparam logic [15:0] OFS_WD_PRESCALER = 16'h0400; // Shared tick prescaler
  localparam logic [15:0] OFS_APP_TIMER = 16'h0410; // Application-side timer
  localparam logic [15:0] OFS_BUS_TIMER = 16'h0420; // Bus-side timer

  // Reset values
  localparam logic [15:0] RST_WD_PRESCALER = 16'h09c2; // 2500 base ticks minus two
  localparam logic [15:0] RST_BUS_TIMER = 16'h03e8; // 1000 watchdog ticks
  localparam logic [15:0] RST_APP_TIMER = 16'h03e8; // Same default as bus side

  // Extra base ticks added to the prescaler value
  localparam logic [16:0] PRESC_OFFSET = 17'h0_0002; // Tick length is prescaler plus this

  // Monitor indices
  localparam int unsigned MON_APP = 0; // Application-side monitor
  localparam int unsigned MON_BUS = 1; // Bus-side monitor
  localparam int unsigned MON_N = 2; // Number of monitors

  // Application state requests, as coded on the request port
  localparam logic [2:0] REQ_INIT = 3'h1; // Request initial state
  localparam logic [2:0] REQ_PREOP = 3'h2; // Request pre-operational state
  localparam logic [2:0] REQ_BOOT = 3'h3; // Request firmware-update state
  localparam logic [2:0] REQ_SAFEOP = 3'h4; // Request safe-operational state
  localparam logic [2:0] REQ_OP_CODE = 3'h5; // Request operational state

  // Application state machine states
  typedef enum logic [2:0] {
    ST_INIT,
    ST_PREOP,
    ST_COPY,
    ST_SAFEOP,
    ST_OP,
    ST_BOOT
  } swsc_state_t;

endpackage : swsc_pkg

// *** core/swsc_top.sv ***
// Watchdog monitors and application state machine of the slave controller
`timescale 1ns/1ps
module swsc_top
  import swsc_pkg::*;
#(
  parameter int unsigned OUT_W = 16 // Width of the output image
) (
  input wire logic core_clk_i, // Core clock, 100 MHz
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire logic [15:0] reg_addr_i, // Register byte offset
  input wire logic [REG_W-1:0] reg_wdata_i, // Register write data
  output logic [REG_W-1:0] reg_rdata_o, // Register read data
  output logic reg_ack_o, // Access answered, one cycle
  input wire logic pd_access_i, // Successful process data access, pulse
  input wire logic app_access_i, // Local application interface access, pulse
  input wire logic state_req_i, // State change request strobe
  input wire logic [2:0] state_code_i, // Requested state code
  input wire logic mbx_cfg_ok_i, // Mailbox channels 0 and 1 valid
  input wire logic pd_cfg_ok_i, // Process data channels and mapping valid
  input wire logic clk_sync_ok_i, // Clock-sync settings valid
  input wire logic copy_done_i, // Input copy to dual-port memory finished
  input wire logic [OUT_W-1:0] out_data_i, // Output data from the master
  input wire logic [OUT_W-1:0] safe_value_i, // Configured safe output value
  output logic copy_inputs_o, // Start input copy, pulse
  output logic state_ack_o, // State change accepted, pulse
  output logic state_err_o, // State change refused, pulse
  output logic [2:0] app_state_o, // Current application state
  output logic bus_wd_expired_o, // Bus-side timeout flag
  output logic app_wd_expired_o, // Application-side timeout flag
  output logic mbx_allowed_o, // Mailbox traffic allowed
  output logic file_xfer_only_o, // Only mailbox file transfer allowed
  output logic pd_allowed_o, // Process data traffic allowed
  output logic inputs_update_o, // Inputs updated cyclically
  output logic [OUT_W-1:0] out_o // Physical output image
);

  // Elaboration-time parameter check
  // The output image must be at least one bit and fit a sensible bus
  if (OUT_W < 1 || OUT_W > 1024) begin : g_chk
    $error("OUT_W out of range");
  end

  // Registers
  // Timers and counters are indexed by monitor, MON_APP and MON_BUS
  logic [REG_W-1:0] presc_reg; // Shared prescaler
  logic [REG_W-1:0] timer_reg [MON_N]; // Per-monitor timers
  logic [REG_W-1:0] rdata_reg; // Read data
  logic ack_reg; // Access answer
  logic [1:0] base_cnt_reg; // Core to base clock divider
  logic base_en_reg; // Base tick enable
  logic [16:0] presc_cnt_reg; // Base ticks within a watchdog tick
  logic wd_tick_reg; // Watchdog tick enable
  logic [REG_W-1:0] mon_cnt_reg [MON_N]; // Ticks since last access
  logic [MON_N-1:0] expired_reg; // Timeout flags
  swsc_state_t state_reg; // Application state
  swsc_state_t state_next; // Next application state
  logic ack_next; // Accept pulse next
  logic err_next; // Refuse pulse next
  logic copy_reg; // Copy request pulse
  logic copy_next; // Copy request next
  logic state_ack_reg; // Accept pulse
  logic state_err_reg; // Refuse pulse
  logic [OUT_W-1:0] out_reg; // Output image

  // Register decode
  // Offsets are full byte addresses; any other address is unmapped
  // Unmapped reads return zero, unmapped writes are dropped, both are answered
  wire sel_presc = reg_addr_i == OFS_WD_PRESCALER; // Prescaler hit
  wire sel_app = reg_addr_i == OFS_APP_TIMER; // Application timer hit
  wire sel_bus = reg_addr_i == OFS_BUS_TIMER; // Bus timer hit
  wire [REG_W-1:0] rd_mux = sel_presc ? presc_reg :
                            sel_app ? timer_reg[MON_APP] :
                            sel_bus ? timer_reg[MON_BUS] : '0; // Unmapped reads zero
  // A tick spans the register value plus two base ticks
  // The sum is one bit wider so the largest register value cannot wrap
  wire [16:0] presc_last = {1'b0, presc_reg} + PRESC_OFFSET - 17'h0_0001; // Last base tick
  wire [MON_N-1:0] mon_access = {pd_access_i, app_access_i}; // Access events per monitor

  // Register write and read; a write strobe to a mapped offset always lands
  // A write lands at the edge that takes the strobe; the next tick uses it
  // Read data is latched once per read and holds until the next read
  // The answer is one registered pulse per access
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      presc_reg <= RST_WD_PRESCALER;
      timer_reg[MON_APP] <= RST_APP_TIMER;
      timer_reg[MON_BUS] <= RST_BUS_TIMER;
      rdata_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      if (reg_wr_i && sel_presc) presc_reg <= reg_wdata_i;
      if (reg_wr_i && sel_app) timer_reg[MON_APP] <= reg_wdata_i;
      if (reg_wr_i && sel_bus) timer_reg[MON_BUS] <= reg_wdata_i;
      if (reg_rd_i) rdata_reg <= rd_mux;
      // Every access is answered, mapped or not
      ack_reg <= reg_rd_i | reg_wr_i;
    end
  end

  // Base clock enable: one pulse every BASE_DIV core cycles
  // The divider runs freely from reset; accesses never touch its phase
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      base_cnt_reg <= '0;
      base_en_reg <= 1'b0;
    end else begin
      base_cnt_reg <= base_cnt_reg + 2'h1;
      // Pulse on the last count so the enable stands one cycle
      base_en_reg <= base_cnt_reg == 2'(BASE_DIV - 1);
    end
  end

  // Shared prescaler: one watchdog tick per prescaler plus two base ticks
  // Both monitors count the same tick, so their phases cannot drift apart
  // A smaller value written mid-count ends the current tick at once
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      presc_cnt_reg <= '0;
      wd_tick_reg <= 1'b0;
    end else begin
      // Tick is a one-cycle pulse, low by default
      wd_tick_reg <= 1'b0;
      if (base_en_reg) begin
        if (presc_cnt_reg >= presc_last) begin
          presc_cnt_reg <= '0;
          wd_tick_reg <= 1'b1;
        end else begin
          presc_cnt_reg <= presc_cnt_reg + 17'h0_0001;
        end
      end
    end
  end

  // Timeout monitors, index 0 local interface, index 1 bus side
  // An access clears the flag even when a tick would set it in that cycle
  // The tick phase is not restarted by an access, so a timeout may come
  // up to one tick early; the count itself always restarts from zero
  // A timer of zero parks the monitor with its flag low
  for (genvar m = 0; m < MON_N; m++) begin : g_mon
    wire enabled = timer_reg[m] != '0;
    // One counter and one flag per monitor
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        mon_cnt_reg[m] <= '0;
        expired_reg[m] <= 1'b0;
      end else if (mon_access[m]) begin
        mon_cnt_reg[m] <= '0;
        expired_reg[m] <= 1'b0;
      end else if (!enabled) begin
        mon_cnt_reg[m] <= '0;
        expired_reg[m] <= 1'b0;
      end else if (wd_tick_reg && !expired_reg[m]) begin
        mon_cnt_reg[m] <= mon_cnt_reg[m] + 16'h0001;
        if (mon_cnt_reg[m] + 16'h0001 >= timer_reg[m]) begin
          expired_reg[m] <= 1'b1;
        end
      end
    end
  end

  // Application state transitions
  // Refused requests answer with a pulse and leave the state alone
  // While the input copy runs, new requests are ignored, not refused
  // Only the initial state may lead to firmware update
  // Downward moves need no checks; moves up into pre-operational and safe-operational check their settings first
  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    copy_next = 1'b0;
    // Copy wait: only the copy-done answer moves the machine on
    if (state_reg == ST_COPY) begin
      if (copy_done_i) begin
        state_next = ST_SAFEOP;
        ack_next = 1'b1;
      end
    end else if (state_req_i) begin
      ack_next = 1'b1;
      // Decode the requested code against the present state
      unique case (state_code_i)
        REQ_INIT: state_next = ST_INIT;
        REQ_PREOP: begin
          if (state_reg == ST_INIT && mbx_cfg_ok_i) state_next = ST_PREOP;
          else if (state_reg == ST_SAFEOP || state_reg == ST_OP || state_reg == ST_PREOP)
            state_next = ST_PREOP;
          else begin
            ack_next = 1'b0;
            err_next = 1'b1;
          end
        end
        REQ_BOOT: begin
          if (state_reg == ST_INIT || state_reg == ST_BOOT) state_next = ST_BOOT;
          else begin
            ack_next = 1'b0;
            err_next = 1'b1;
          end
        end
        REQ_SAFEOP: begin
          if (state_reg == ST_PREOP && pd_cfg_ok_i && clk_sync_ok_i) begin
            state_next = ST_COPY;
            copy_next = 1'b1;
            ack_next = 1'b0;
          end else if (state_reg == ST_OP || state_reg == ST_SAFEOP) state_next = ST_SAFEOP;
          else begin
            ack_next = 1'b0;
            err_next = 1'b1;
          end
        end
        REQ_OP_CODE: begin
          if (state_reg == ST_SAFEOP || state_reg == ST_OP) state_next = ST_OP;
          else begin
            ack_next = 1'b0;
            err_next = 1'b1;
          end
        end
        default: begin
          ack_next = 1'b0;
          err_next = 1'b1;
        end
      endcase
    end
  end

  // State register; a bus timeout leaves the state where it is
  // Answer pulses are registered so each stands for exactly one cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_INIT;
      state_ack_reg <= 1'b0;
      state_err_reg <= 1'b0;
      copy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      state_ack_reg <= ack_next;
      state_err_reg <= err_next;
      copy_reg <= copy_next;
    end
  end

  // Output image: master data only in operational without a bus timeout
  // Every other state, and any pending bus timeout, shows the safe value
  // The safe value is taken each cycle, so a new preset shows one cycle later
  wire out_live = state_reg == ST_OP && !expired_reg[MON_BUS];
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) out_reg <= '0;
    else if (out_live) out_reg <= out_data_i;
    else out_reg <= safe_value_i;
  end

  // Traffic permissions and status, all registered
  // Decoded from the next state so they change in step with the state port
  // File transfer only is set alongside mailbox in firmware update
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mbx_allowed_o <= 1'b0;
      file_xfer_only_o <= 1'b0;
      pd_allowed_o <= 1'b0;
      inputs_update_o <= 1'b0;
      app_state_o <= '0;
      bus_wd_expired_o <= 1'b0;
      app_wd_expired_o <= 1'b0;
    end else begin
      mbx_allowed_o <= state_next != ST_INIT;
      file_xfer_only_o <= state_next == ST_BOOT;
      pd_allowed_o <= state_next == ST_SAFEOP || state_next == ST_OP;
      inputs_update_o <= state_next == ST_SAFEOP || state_next == ST_OP;
      app_state_o <= state_next;
      bus_wd_expired_o <= expired_reg[MON_BUS];
      app_wd_expired_o <= expired_reg[MON_APP];
    end
  end

  // Outputs come straight from their flip-flops
  assign reg_rdata_o = rdata_reg;
  assign reg_ack_o = ack_reg;
  assign copy_inputs_o = copy_reg;
  assign state_ack_o = state_ack_reg;
  assign state_err_o = state_err_reg;
  assign out_o = out_reg;

endmodule : swsc_top

// *** sim/swsc_master_model.sv ***
// Behavioural bus master and local processor facing the block
`timescale 1ns/1ps
module swsc_master_model (
  input wire logic core_clk_i, // Core clock
  input wire logic pd_en_i, // Keep process data traffic going
  input wire logic app_en_i, // Keep local accesses going
  input wire logic copy_req_i, // Input copy started
  output logic pd_access_o, // Process data access pulse
  output logic app_access_o, // Local access pulse
  output logic copy_done_o, // Input copy finished pulse
  output logic [15:0] out_data_o // Output image from the master
);
  logic [2:0] cnt_reg = 3'h0; // Access pacing
  logic [3:0] pipe_reg = 4'h0; // Copy delay, pulses out on top
  logic pd_reg = 1'b0; // Registered bus access
  logic app_reg = 1'b0; // Registered local access
  // One access of each kind every eight cycles, copy answered late
  always_ff @(posedge core_clk_i) begin
    cnt_reg <= cnt_reg + 3'h1;
    pd_reg <= pd_en_i && cnt_reg == 3'h0;
    app_reg <= app_en_i && cnt_reg == 3'h4;
    pipe_reg <= {pipe_reg[2:0], copy_req_i};
  end
  assign pd_access_o = pd_reg;
  assign app_access_o = app_reg;
  assign copy_done_o = pipe_reg[3];
  // Valid output data stands before any operational request
  assign out_data_o = 16'ha5c3;
endmodule : swsc_master_model

// *** sim/swsc_top_asserts.sv ***
// Port assertions of the watchdog and state block
`timescale 1ns/1ps
module swsc_top_asserts
  import swsc_pkg::*;
#(
  parameter int unsigned OUT_W = 16 // Output image width
) (
  input wire logic core_clk_i, // Core clock
  input wire logic sys_rst_i, // Reset
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic reg_ack_o, // Access answer
  input wire logic pd_access_i, // Bus access
  input wire logic state_req_i, // State request
  input wire logic [2:0] state_code_i, // Requested code
  input wire logic pd_cfg_ok_i, // Data setup valid
  input wire logic clk_sync_ok_i, // Sync setup valid
  input wire logic copy_done_i, // Copy finished
  input wire logic [OUT_W-1:0] out_data_i, // Master data
  input wire logic [OUT_W-1:0] safe_value_i, // Safe value
  input wire logic copy_inputs_o, // Copy start
  input wire logic state_ack_o, // Accepted
  input wire logic state_err_o, // Refused
  input wire logic [2:0] app_state_o, // State
  input wire logic bus_wd_expired_o, // Bus timeout
  input wire logic mbx_allowed_o, // Mailbox allowed
  input wire logic file_xfer_only_o, // File transfer only
  input wire logic pd_allowed_o, // Data allowed
  input wire logic [OUT_W-1:0] out_o // Output image
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Granted move towards safe-operational, then copy before answer
  sequence s_safe_req;
    state_req_i && state_code_i == REQ_SAFEOP && app_state_o == ST_PREOP
      && pd_cfg_ok_i && clk_sync_ok_i;
  endsequence
  sequence s_copy_wait;
    copy_inputs_o && !state_ack_o && app_state_o == ST_COPY;
  endsequence
  chk_reg_ack: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
    else $error("register access unanswered");
  chk_bus_clear: assert property (pd_access_i |-> ##2 !bus_wd_expired_o)
    else $error("bus timeout not cleared");
  chk_bus_sticky: assert property ($fell(bus_wd_expired_o) |->
    $past(pd_access_i, 2) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
    else $error("bus timeout dropped alone");
  chk_state_kept: assert property ($rose(bus_wd_expired_o) |-> $stable(app_state_o))
    else $error("state moved on timeout");
  chk_safe_out: assert property (bus_wd_expired_o && !$past(pd_access_i) |=>
    out_o == $past(safe_value_i))
    else $error("output not safe on timeout");
  chk_op_follow: assert property ((app_state_o == ST_OP && !bus_wd_expired_o) [*2] |->
    out_o == $past(out_data_i))
    else $error("output not following master");
  chk_init_none: assert property (app_state_o == ST_INIT [*2] |->
    !mbx_allowed_o && !pd_allowed_o)
    else $error("traffic allowed in initial");
  chk_boot_perm: assert property (app_state_o == ST_BOOT [*2] |->
    mbx_allowed_o && file_xfer_only_o && !pd_allowed_o)
    else $error("wrong firmware-update traffic");
  chk_boot_entry: assert property (state_req_i && state_code_i == REQ_BOOT &&
    app_state_o inside {ST_PREOP, ST_SAFEOP, ST_OP} |=> state_err_o)
    else $error("firmware-update entry not refused");
  chk_copy_first: assert property (s_safe_req |=> s_copy_wait)
    else $error("no copy before answer");
  chk_copy_ack: assert property (app_state_o == ST_COPY && copy_done_i |=>
    state_ack_o && app_state_o == ST_SAFEOP)
    else $error("copy end not acknowledged");
endmodule : swsc_top_asserts
bind swsc_top swsc_top_asserts #(.OUT_W(OUT_W)) u_asserts (.core_clk_i, .sys_rst_i,
  .reg_wr_i, .reg_rd_i, .reg_ack_o, .pd_access_i, .state_req_i, .state_code_i,
  .pd_cfg_ok_i, .clk_sync_ok_i, .copy_done_i, .out_data_i, .safe_value_i, .copy_inputs_o,
  .state_ack_o, .state_err_o, .app_state_o, .bus_wd_expired_o, .mbx_allowed_o,
  .file_xfer_only_o, .pd_allowed_o, .out_o);

// *** sim/swsc_tb_top.sv ***
// Self-checking bench of the watchdog and state block
`timescale 1ns/1ps
module swsc_tb_top import swsc_pkg::*;;
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0;
  logic mbx_ok = 1'b0, pd_en = 1'b1, app_en = 1'b1, ack, pd_acc, app_acc, cp_go, cp_done;
  logic s_ack, s_err, bus_exp, app_exp, mbx_al, fx_only, pd_al, in_upd;
  logic pd_ok = 1'b0, sync_ok = 1'b1; // Process data and clock-sync setup valid
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, rdata, out_data, out_img;
  logic [15:0] safe_val = 16'h00f0; // Preset safe image
  logic [2:0] code = 3'h0, st; // Request code and state
  logic [2:0] bad [4] = '{3'h0, 3'h5, 3'h6, 3'h7}; // Refused from firmware-update
  int fails = 0, n_checks = 0, n;
  // Clock at 100 MHz
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  swsc_top #(.OUT_W(16)) uut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .pd_access_i(pd_acc), .app_access_i(app_acc), .state_req_i(req),
    .state_code_i(code), .mbx_cfg_ok_i(mbx_ok), .pd_cfg_ok_i(pd_ok), .clk_sync_ok_i(sync_ok),
    .copy_done_i(cp_done), .out_data_i(out_data), .safe_value_i(safe_val),
    .copy_inputs_o(cp_go), .state_ack_o(s_ack), .state_err_o(s_err), .app_state_o(st),
    .bus_wd_expired_o(bus_exp), .app_wd_expired_o(app_exp), .mbx_allowed_o(mbx_al),
    .file_xfer_only_o(fx_only), .pd_allowed_o(pd_al), .inputs_update_o(in_upd), .out_o(out_img));
  swsc_master_model u_far (.core_clk_i(core_clk), .pd_en_i(pd_en), .app_en_i(app_en),
    .copy_req_i(cp_go), .pd_access_o(pd_acc), .app_access_o(app_acc),
    .copy_done_o(cp_done), .out_data_o(out_data));
  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One register access; a read compares against d
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    for (n = 0; n < 4 && ack !== 1'b1; n++) @(negedge core_clk);
    check({15'h0, ack}, 16'h0001);
    if (!w) check(rdata, d);
  endtask : acc
  // One state request; good says whether it must be accepted
  task automatic req_state(input logic [2:0] c, input logic good);
    @(posedge core_clk);
    req <= 1'b1;
    code <= c;
    @(posedge core_clk);
    req <= 1'b0;
    for (n = 0; n < 12 && s_ack !== 1'b1 && s_err !== 1'b1; n++) @(negedge core_clk);
    check({14'h0, s_ack, s_err}, {14'h0, good, !good});
  endtask : req_state
  // Cycles from the last access until a timeout flag rises
  task automatic wait_hi(input logic app);
    for (n = 0; n < 60 && (app ? app_exp : bus_exp) !== 1'b1; n++) begin
      @(negedge core_clk);
      if ((app ? app_acc : pd_acc) === 1'b1) n = 0;
    end
  endtask : wait_hi
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Hang guard
  initial begin
    #50_000;
    fails++;
    wrap_up();
  end
  // Test sequence
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    acc(1'b0, OFS_WD_PRESCALER, RST_WD_PRESCALER);
    acc(1'b0, OFS_BUS_TIMER, RST_BUS_TIMER);
    acc(1'b0, OFS_APP_TIMER, RST_APP_TIMER);
    acc(1'b0, 16'h0430, 16'h0000);
    acc(1'b1, OFS_WD_PRESCALER, 16'h0000);
    acc(1'b1, OFS_BUS_TIMER, 16'h0003);
    acc(1'b1, OFS_APP_TIMER, 16'h0003);
    acc(1'b0, OFS_WD_PRESCALER, 16'h0000);
    $display("test registers done");
    check({11'h0, mbx_al, pd_al, st}, 16'h0000);
    req_state(REQ_PREOP, 1'b0);
    @(posedge core_clk) mbx_ok <= 1'b1;
    req_state(REQ_PREOP, 1'b1);
    req_state(REQ_BOOT, 1'b0);
    req_state(REQ_SAFEOP, 1'b0);
    @(posedge core_clk) {pd_ok, sync_ok} <= 2'b10;
    req_state(REQ_SAFEOP, 1'b0);
    @(posedge core_clk) sync_ok <= 1'b1;
    req_state(REQ_SAFEOP, 1'b1);
    check({11'h0, mbx_al, pd_al, in_upd, 2'h0}, {11'h0, 3'h7, 2'h0});
    check(out_img, safe_val);
    req_state(REQ_OP_CODE, 1'b1);
    repeat (2) @(negedge core_clk);
    check(out_img, out_data);
    $display("test states done");
    @(posedge core_clk) pd_en <= 1'b0;
    wait_hi(1'b0);
    check({15'h0, n >= 16 && n <= 36}, 16'h0001);
    check({13'h0, st}, {13'h0, ST_OP});
    repeat (40) @(negedge core_clk);
    check({15'h0, bus_exp}, 16'h0001);
    check(out_img, safe_val);
    @(posedge core_clk) pd_en <= 1'b1;
    repeat (12) @(negedge core_clk);
    check({15'h0, bus_exp}, 16'h0000);
    acc(1'b1, OFS_BUS_TIMER, 16'h0000);
    acc(1'b0, OFS_APP_TIMER, 16'h0003);
    @(posedge core_clk) pd_en <= 1'b0;
    repeat (80) @(negedge core_clk);
    check({15'h0, bus_exp}, 16'h0000);
    check(out_img, out_data);
    $display("test bus watchdog done");
    @(posedge core_clk) app_en <= 1'b0;
    wait_hi(1'b1);
    check({15'h0, n >= 16 && n <= 36}, 16'h0001);
    @(posedge core_clk) app_en <= 1'b1;
    repeat (12) @(negedge core_clk);
    check({15'h0, app_exp}, 16'h0000);
    $display("test local watchdog done");
    req_state(REQ_SAFEOP, 1'b1);
    req_state(REQ_PREOP, 1'b1);
    req_state(REQ_OP_CODE, 1'b0);
    check({13'h0, mbx_al, pd_al, in_upd}, 16'h0004);
    req_state(REQ_INIT, 1'b1);
    req_state(REQ_BOOT, 1'b1);
    repeat (2) @(negedge core_clk);
    check({13'h0, mbx_al, fx_only, pd_al}, 16'h0006);
    foreach (bad[i]) req_state(bad[i], 1'b0);
    $display("test firmware-update done");
    wrap_up();
  end
endmodule : swsc_tb_top
